// file: bench/ffc_frame_filter_control_test.sv
// self-checking bench for the frame filter control register block
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
  $display("BAD %0t got %h want %h", $time, (a), (b)); end end
module ffc_frame_filter_control_test;
  import ffc_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic reg_req_i = 1'b0;
  ffc_op_t reg_op_i = FFC_OP_WRITE;
  logic [6:0] reg_addr_i = 7'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic fcf_valid_i = 1'b0;
  logic [15:0] fcf_i = 16'h0000;
  logic addr_done_i = 1'b0;
  logic addr_ok_i = 1'b0;
  logic dest_present_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic reg_hit_o;
  logic decide_o;
  logic accept_o;
  logic [7:0] ctrl_o;
  int failures = 0;
  int compares = 0;
  ffc_frame_filter_control dut (
    .clock_i(clock_i), .rst_i(rst_i), .reg_req_i(reg_req_i),
    .reg_op_i(reg_op_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_hit_o(reg_hit_o), .fcf_valid_i(fcf_valid_i), .fcf_i(fcf_i),
    .addr_done_i(addr_done_i), .addr_ok_i(addr_ok_i),
    .dest_present_i(dest_present_i), .decide_o(decide_o),
    .accept_o(accept_o), .ctrl_o(ctrl_o)
  );
  // 50 ns period, 20 MHz
  initial begin
    forever #25 clock_i = ~clock_i;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  // verdict; both the main sequence and the watchdog end here
  task automatic complete_run();
    if (failures == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // one access; the answer shows the view from before the access
  task automatic acc(input ffc_op_t op, input logic [6:0] a,
                     input logic [7:0] wd, input logic [7:0] rd,
                     input logic hit);
    @(negedge clock_i);
    reg_req_i = 1'b1;
    reg_op_i = op;
    reg_addr_i = a;
    reg_wdata_i = wd;
    @(negedge clock_i);
    reg_req_i = 1'b0;
    `CHK(reg_hit_o, hit)
    `CHK(reg_rdata_o, rd)
  endtask
  // one frame: fcf, then address fields next cycle, then one idle cycle
  task automatic frm(input logic [15:0] f, input logic dst,
                     input logic ok, input logic acc_exp);
    @(negedge clock_i);
    fcf_valid_i = 1'b1;
    fcf_i = f;
    @(negedge clock_i);
    fcf_valid_i = 1'b0;
    addr_done_i = 1'b1;
    dest_present_i = dst;
    addr_ok_i = ok;
    @(negedge clock_i);
    addr_done_i = 1'b0;
    `CHK(decide_o, 1'b1)
    `CHK(accept_o, acc_exp)
    @(negedge clock_i);
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  // watchdog far beyond the roughly 60 cycles the tests need
  initial begin
    repeat (3000) @(posedge clock_i);
    failures++;
    complete_run();
  end
  initial begin
    repeat (8) @(negedge clock_i);
    rst_i = 1'b0;
    `CHK(ctrl_o, 8'h0D)
    `CHK(decide_o, 1'b0)
    acc(FFC_OP_SET, 7'h00, 8'h00, 8'h0D, 1'b1);
    acc(FFC_OP_SET, 7'h00, 8'h02, 8'h0D, 1'b1);
    `CHK(ctrl_o, 8'h0F)
    acc(FFC_OP_SET, 7'h00, 8'h00, 8'h0F, 1'b1);
    `CHK(ctrl_o, 8'h0F)
    acc(FFC_OP_CLEAR, 7'h00, 8'hFD, 8'h0F, 1'b1);
    `CHK(ctrl_o, 8'h0D)
    acc(FFC_OP_CLEAR, 7'h00, 8'hFF, 8'h0D, 1'b1);
    `CHK(ctrl_o, 8'h0D)
    // unmapped address: no hit, zero data, no change
    acc(FFC_OP_WRITE, 7'h03, 8'hFF, 8'h00, 1'b0);
    `CHK(ctrl_o, 8'h0D)
    // mask 001, maximum version 00, enabled
    acc(FFC_OP_WRITE, 7'h00, 8'h11, 8'h0D, 1'b1);
    `CHK(ctrl_o, 8'h11)
    frm(16'h0080, 1'b1, 1'b1, 1'b0);
    frm(16'h0100, 1'b1, 1'b1, 1'b1);
    frm(16'h1000, 1'b1, 1'b1, 1'b0);
    frm(16'h0000, 1'b1, 1'b0, 1'b0);
    acc(FFC_OP_WRITE, 7'h00, 8'h0D, 8'h11, 1'b1);
    frm(16'h3000, 1'b1, 1'b1, 1'b1);
    frm(16'h0000, 1'b0, 1'b1, 1'b0);
    acc(FFC_OP_SET, 7'h00, 8'h02, 8'h0D, 1'b1);
    frm(16'h0000, 1'b0, 1'b0, 1'b1);
    // everything armed but the enable: filter must pass all
    acc(FFC_OP_WRITE, 7'h00, 8'h7C, 8'h0F, 1'b1);
    `CHK(ctrl_o, 8'h7C)
    acc(FFC_OP_SET, 7'h00, 8'h00, 8'h00, 1'b1);
    frm(16'h3380, 1'b0, 1'b0, 1'b1);
    complete_run();
  end
endmodule

// file: rtl/ffc_frame_filter_control.sv
// frame filter control register with per-frame accept decision
`timescale 1ns/1ps
// What this block does
// R1 - bit-set access: ones set, zeros untouched
// R2 - bit-clear access: zeros clear, ones untouched
// R3 - read returns value the filter uses
// R4 - software writes zero to bit 7; the block stores bit 7 as written and does not force it to zero
// R5 - reserved FCF bits masked reject frame
// R6 - frame version above maximum rejects frame
// R7 - coordinator flag accepts destination-less frames
// R8 - enable bit turns on third-level filtering
// R9 - disabled filter ignores other config bits
// R10 - decide after FCF and addresses arrive
module ffc_frame_filter_control
  import ffc_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // register access port
  input wire logic reg_req_i,
  input wire ffc_pkg::ffc_op_t reg_op_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_hit_o,
  // receive side
  input wire logic fcf_valid_i,
  input wire logic [15:0] fcf_i,
  input wire logic addr_done_i,
  input wire logic addr_ok_i,
  input wire logic dest_present_i,
  // decision
  output logic decide_o,
  output logic accept_o,
  // stored control register, without the masking the filter applies when disabled
  output logic [7:0] ctrl_o
);
  import ffc_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl;
    ffc_state_t st;
    logic fail;
    logic [7:0] rdata;
    logic hit;
    logic decide;
    logic accept;
  } ffc_state_s_t;

  ffc_state_s_t r;
  ffc_state_s_t next_r;
  logic [7:0] view;
  logic fcf_bad;

  // ----------------------------------------------------------------
  // effective view and frame checks
  // ----------------------------------------------------------------
  // with filtering off, fields 6:1 read as the value used: zero
  always_comb begin
    view = r.ctrl[FFC_BIT_EN] ? r.ctrl : (r.ctrl & 8'h81); // R3 R9
    fcf_bad = 1'b0;
    if (view[FFC_BIT_EN]) begin
      if ((view[FFC_MASK_LSB +: 3] & fcf_i[FCF_RSVD_LSB +: 3]) != 3'h0) begin
        fcf_bad = 1'b1; // R5
      end
      if (fcf_i[FCF_VER_LSB +: 2] > view[FFC_VER_LSB +: 2]) begin
        fcf_bad = 1'b1; // R6
      end
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.decide = 1'b0;
    next_r.hit = 1'b0;
    // register access; bit 7 is stored as written, software keeps it 0
    if (reg_req_i) begin
      if (reg_addr_i == FFC_ADDR_CTRL) begin
        next_r.hit = 1'b1;
        unique case (reg_op_i)
          FFC_OP_WRITE: next_r.ctrl = reg_wdata_i; // R4
          FFC_OP_SET: next_r.ctrl = r.ctrl | reg_wdata_i; // R1
          // a zero in the mask clears its bit, a one leaves it alone
          FFC_OP_CLEAR: next_r.ctrl = r.ctrl & reg_wdata_i; // R2
          default: next_r.ctrl = r.ctrl;
        endcase
        next_r.rdata = view; // R3
      end else begin
        next_r.rdata = 8'h00;
      end
    end
    // frame decision sequence
    unique case (r.st)
      FFC_IDLE: begin
        if (fcf_valid_i) begin
          next_r.fail = fcf_bad;
          next_r.st = FFC_WAIT_ADDR;
        end
      end
      FFC_WAIT_ADDR: begin
        if (addr_done_i) begin // R10
          next_r.st = FFC_DONE;
          next_r.decide = 1'b1;
          if (!view[FFC_BIT_EN]) begin
            next_r.accept = 1'b1; // R8 R9
          end else if (!dest_present_i) begin
            next_r.accept = !r.fail && view[FFC_BIT_COORD]; // R7
          end else begin
            next_r.accept = !r.fail && addr_ok_i; // R10
          end
        end
      end
      FFC_DONE: next_r.st = FFC_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      r.ctrl <= FFC_CTRL_RESET; // R8
      r.st <= FFC_IDLE;
      r.fail <= 1'b0;
      r.rdata <= 8'h00;
      r.hit <= 1'b0;
      r.decide <= 1'b0;
      r.accept <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign reg_rdata_o = r.rdata;
  assign reg_hit_o = r.hit;
  assign decide_o = r.decide;
  assign accept_o = r.accept;
  assign ctrl_o = r.ctrl;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_set_only;
    @(posedge clock_i) disable iff (rst_i)
    reg_req_i && reg_addr_i == FFC_ADDR_CTRL && reg_op_i == FFC_OP_SET
      |=> ctrl_o == ($past(ctrl_o) | $past(reg_wdata_i));
  endproperty
  a_set_only: assert property (p_set_only) // R1
    else $error("bit-set access wrong");

  property p_clear_only;
    @(posedge clock_i) disable iff (rst_i)
    reg_req_i && reg_addr_i == FFC_ADDR_CTRL && reg_op_i == FFC_OP_CLEAR
      |=> ctrl_o == ($past(ctrl_o) & $past(reg_wdata_i));
  endproperty
  a_clear_only: assert property (p_clear_only) // R2
    else $error("bit-clear access wrong");

  property p_read_view;
    @(posedge clock_i) disable iff (rst_i)
    reg_req_i && reg_addr_i == FFC_ADDR_CTRL && !ctrl_o[0]
      |=> reg_rdata_o[6:1] == 6'h00 && reg_hit_o;
  endproperty
  a_read_view: assert property (p_read_view) // R3
    else $error("read does not show used value");

  property p_write;
    @(posedge clock_i) disable iff (rst_i)
    reg_req_i && reg_addr_i == FFC_ADDR_CTRL && reg_op_i == FFC_OP_WRITE
      |=> ctrl_o == $past(reg_wdata_i);
  endproperty
  a_write: assert property (p_write) // R4
    else $error("plain write wrong");

  property p_mask_reject;
    @(posedge clock_i) disable iff (rst_i)
    r.st == FFC_IDLE && fcf_valid_i && ctrl_o[0]
      && (ctrl_o[6:4] & fcf_i[9:7]) != 3'h0 && !reg_req_i
      ##1 (addr_done_i && r.st == FFC_WAIT_ADDR) |=> decide_o && !accept_o;
  endproperty
  a_mask_reject: assert property (p_mask_reject) // R5
    else $error("reserved bits not rejected");

  property p_version_reject;
    @(posedge clock_i) disable iff (rst_i)
    r.st == FFC_IDLE && fcf_valid_i && ctrl_o[0] && !reg_req_i
      && fcf_i[13:12] > ctrl_o[3:2]
      ##1 (addr_done_i && r.st == FFC_WAIT_ADDR) |=> !accept_o;
  endproperty
  a_version_reject: assert property (p_version_reject) // R6
    else $error("version not rejected");

  property p_coord;
    @(posedge clock_i) disable iff (rst_i)
    r.st == FFC_WAIT_ADDR && addr_done_i && ctrl_o[0] && !dest_present_i
      && !ctrl_o[1] |=> decide_o && !accept_o;
  endproperty
  a_coord: assert property (p_coord) // R7
    else $error("destination-less accepted without coordinator");

  property p_disabled;
    @(posedge clock_i) disable iff (rst_i)
    r.st == FFC_WAIT_ADDR && addr_done_i && !ctrl_o[0]
      |=> decide_o && accept_o;
  endproperty
  a_disabled: assert property (p_disabled) // R8 R9
    else $error("disabled filter rejected frame");

  property p_decide_time;
    @(posedge clock_i) disable iff (rst_i)
    r.st == FFC_WAIT_ADDR && addr_done_i |=> decide_o ##1 !decide_o;
  endproperty
  a_decide_time: assert property (p_decide_time) // R10
    else $error("decision pulse wrong");

  c_accept: cover property (@(posedge clock_i) decide_o && accept_o);
  c_reject: cover property (@(posedge clock_i) decide_o && !accept_o);
  c_set: cover property (@(posedge clock_i)
    reg_req_i && reg_op_i == FFC_OP_SET);
endmodule

// file: rtl/ffc_pkg.sv
// package of constants and types for the frame filter control block
package ffc_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [6:0] FFC_ADDR_CTRL = 7'h00; // frame_filter_control
  localparam logic [6:0] FFC_ADDR_FTYPE = 7'h01; // frame_type_accept_control
  localparam logic [6:0] FFC_ADDR_SRCM = 7'h02; // source match control
  localparam logic [7:0] FFC_CTRL_RESET = 8'h0D;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FFC_BIT_EN = 0;
  localparam int FFC_BIT_COORD = 1;
  localparam int FFC_VER_LSB = 2;
  localparam int FFC_MASK_LSB = 4;
  localparam int FFC_BIT_RSVD = 7;
  localparam int FCF_RSVD_LSB = 7;
  localparam int FCF_VER_LSB = 12;
  // access operations on the register port
  typedef enum logic [1:0] {
    FFC_OP_WRITE,
    FFC_OP_SET,
    FFC_OP_CLEAR
  } ffc_op_t;
  // decision states
  typedef enum logic [1:0] {
    FFC_IDLE,
    FFC_WAIT_ADDR,
    FFC_DONE
  } ffc_state_t;
endpackage
